/* hdl/nand_host_pkg.sv */
// Shared constants and types for the NAND flash host controller.
package nand_host_pkg;
  // Clock and pin timing: times in ns, counts rounded up to whole cycles.
  localparam int CLOCK_NS = 20;
  localparam int STROBE_LOW_NS = 25;
  localparam int STROBE_HIGH_NS = 15;
  localparam int BUSY_SETTLE_NS = 100;
  localparam logic [2:0] LOW_COUNT = 3'((STROBE_LOW_NS + CLOCK_NS - 1) / CLOCK_NS - 1);
  localparam logic [2:0] HIGH_COUNT = 3'((STROBE_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS - 1);
  localparam logic [2:0] SETTLE_COUNT = 3'((BUSY_SETTLE_NS + CLOCK_NS - 1) / CLOCK_NS - 1);
  // Array geometry.
  localparam int BLOCKS = 1024;
  localparam logic [11:0] PAGE_LAST_COL = 12'h83f;
  localparam logic [11:0] MAIN_SEG_BYTES = 12'h200;
  localparam logic [11:0] SPARE_SEG_BYTES = 12'h010;
  localparam logic [11:0] SPARE_BASE = 12'h800;
  // Device command bytes.
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;
  // Device status bit positions.
  localparam int ST_FAIL = 0;
  // Software register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CONFIG = 8'h10;
  localparam logic [7:0] REG_BLOCKINFO = 8'h14;
  // Operation codes in the control register, bits 2:0.
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_STATUS = 3'h2;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_PROGRAM = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h5;
  localparam logic [2:0] OP_MARKBAD = 3'h6;
  // Address register field positions.
  localparam int FLD_BLOCK_LSB = 0;
  localparam int FLD_PAGE_LSB = 10;
  localparam int FLD_SEG_LSB = 16;
  // Reset values.
  localparam logic [18:0] ADDR_RESET = 19'h00000;
  localparam logic CONFIG_RESET = 1'b0;
  // Kind of one byte cycle on the pins.
  typedef enum logic [1:0] {KIND_CMD, KIND_ADDR, KIND_WRITE, KIND_READ} cycle_kind_type;
endpackage

/* hdl/nand_cycle_if.sv */
// Request and answer signals between the sequencer and the byte cycle engine.
`timescale 1ns/100ps
`default_nettype none
interface nand_cycle_if
  import nand_host_pkg::*;
  ();
  logic req;
  cycle_kind_type kind;
  logic [7:0] wByte;
  logic done;
  logic [7:0] rByte;
  modport seq (output req, output kind, output wByte, input done, input rByte);
  modport engine (input req, input kind, input wByte, output done, output rByte);
endinterface
`default_nettype wire

/* hdl/nand_cycle.sv */
// Byte cycle engine: one command, address, write or read cycle on the pins.
`timescale 1ns/100ps
`default_nettype none
module nand_cycle
  import nand_host_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  nand_cycle_if.engine cyc,
  input wire logic [7:0] ioIn,
  output logic [7:0] ioOut,
  output logic ioOe,
  output logic cle,
  output logic ale,
  output logic writeStrobeN,
  output logic readStrobeN
);
  typedef enum logic [1:0] {CY_IDLE, CY_LOW, CY_HIGH} cyc_state_type;
  cyc_state_type state;
  logic [2:0] count;

  // Strobe low phase, then high phase; latches and bus are held until done.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= CY_IDLE;
      count <= 3'h0;
      cyc.done <= 1'b0;
      cyc.rByte <= 8'h00;
      ioOut <= 8'h00;
      ioOe <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      writeStrobeN <= 1'b1;
      readStrobeN <= 1'b1;
    end
    else
    begin
      cyc.done <= 1'b0;
      case (state)
        CY_IDLE:
          if (cyc.req)
          begin
            state <= CY_LOW;
            count <= LOW_COUNT;
            cle <= (cyc.kind == KIND_CMD);
            ale <= (cyc.kind == KIND_ADDR);
            ioOe <= (cyc.kind != KIND_READ);
            ioOut <= cyc.wByte;
            writeStrobeN <= (cyc.kind == KIND_READ);
            readStrobeN <= (cyc.kind != KIND_READ);
          end
        CY_LOW:
          if (count == 3'h0)
          begin
            // Read data is sampled just before the read strobe rises.
            if (!readStrobeN)
              cyc.rByte <= ioIn;
            writeStrobeN <= 1'b1;
            readStrobeN <= 1'b1;
            state <= CY_HIGH;
            count <= HIGH_COUNT;
          end
          else
            count <= count - 3'h1;
        CY_HIGH:
          if (count == 3'h0)
          begin
            cle <= 1'b0;
            ale <= 1'b0;
            ioOe <= 1'b0;
            state <= CY_IDLE;
            cyc.done <= 1'b1;
          end
          else
            count <= count - 3'h1;
        default:
          state <= CY_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* hdl/nand_host.sv */
// NAND flash host controller: software registers, operation sequencer, block tables.
// Notes on behaviour
// [RULE_01] After serial input only confirm or reset.
// [RULE_02] Other command after serial input cancels program.
// [RULE_03] Program pages ascending within each block.
// [RULE_04] Status command ends read mode until a read command.
// [RULE_05] Never request status during a read.
// [RULE_06] Read command after status resumes at column.
// [RULE_07] Write protect low aborts and blocks program/erase.
// [RULE_08] Fifth address cycle is ignored by device.
// [RULE_09] Page programmable in eight separate segment passes.
// [RULE_10] Four 512-byte main, four 16-byte spare segments.
// [RULE_11] Bytes outside programmed segment are sent all-ones.
// [RULE_12] Good blocks ship all-ones; others are bad.
// [RULE_13] Never erase a block marked bad.
// [RULE_14] Up to twenty shipped bad blocks tolerated.
// [RULE_15] Read status after program/erase; failure flags replacement.
// [RULE_16] Failed erase marks block bad, later accesses refused.
// [RULE_17] Single-bit failures: verify and retry, or ECC.
// [RULE_18] Status byte: bit0 fail, bit5 ready, bit7 unprotected.
// [RULE_19] While busy issue only status or reset.
// [RULE_20] Reset command stops operations, device returns idle.
// [RULE_21] Track next programmable page per block.
`timescale 1ns/100ps
`default_nettype none
module nand_host
  import nand_host_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic [7:0] ioIn,
  output logic [7:0] ioOut,
  output logic ioOe,
  output logic cle,
  output logic ale,
  output logic chipEnableN,
  output logic writeStrobeN,
  output logic readStrobeN,
  output logic writeProtectN,
  input wire logic readyBusyOutput
);
  typedef enum logic [3:0] {S_IDLE, S_CMD1, S_ADDR, S_DATA, S_CMD2, S_SETTLE, S_WAIT,
    S_STCMD, S_STRD, S_READ, S_END} seq_state_type;

  nand_cycle_if cyc ();
  seq_state_type state;
  logic issued;
  logic [2:0] op;
  logic [7:0] firstCmd;
  logic [7:0] secondCmd;
  logic [1:0] addrIdx;
  logic [11:0] col;
  logic [11:0] left;
  logic [18:0] addrReg;
  logic [7:0] devStatus;
  logic [7:0] wrByte;
  logic wrFull;
  logic [7:0] rdByte;
  logic rdValid;
  logic refused;
  logic failed;
  logic abortReq;
  logic [2:0] settle;
  logic badBlock [0:BLOCKS-1];
  logic [6:0] nextPage [0:BLOCKS-1];
  logic [9:0] blk;
  logic [5:0] page;
  logic [2:0] seg;
  logic inSeg;
  logic startWr;
  logic [2:0] startOp;
  logic okToStart;

  // Start column of a segment: four main, then four spare segments.
  // [RULE_10] segment boundary map
  function automatic logic [11:0] segStart(input logic [2:0] s);
    segStart = s[2] ? SPARE_BASE + SPARE_SEG_BYTES * {10'h000, s[1:0]}
                    : MAIN_SEG_BYTES * {10'h000, s[1:0]};
  endfunction

  function automatic logic [11:0] segLen(input logic [2:0] s);
    segLen = s[2] ? SPARE_SEG_BYTES : MAIN_SEG_BYTES;
  endfunction

  // Address byte by index: two column cycles, then two row cycles.
  // [RULE_08] at most four cycles (two for erase), never a fifth
  function automatic logic [7:0] addrByte(input logic [1:0] i, input logic [11:0] c,
    input logic [9:0] b, input logic [5:0] p);
    case (i)
      2'h0: addrByte = c[7:0];
      2'h1: addrByte = {4'h0, c[11:8]};
      2'h2: addrByte = {b[1:0], p};
      default: addrByte = b[9:2];
    endcase
  endfunction

  assign blk = addrReg[FLD_BLOCK_LSB +: 10];
  assign page = addrReg[FLD_PAGE_LSB +: 6];
  assign seg = addrReg[FLD_SEG_LSB +: 3];
  assign inSeg = (col >= segStart(seg)) && (col < segStart(seg) + segLen(seg));
  assign startWr = regWrite && (regAddr == REG_CTRL);
  assign startOp = regWdata[2:0];

  // Admission check for a new operation.
  always_comb
  begin
    okToStart = 1'b1;
    case (startOp)
      OP_PROGRAM:
        // [RULE_03] ascending page order
        // [RULE_21] next-page table check
        okToStart = !badBlock[blk] && writeProtectN && ({1'b0, page} + 7'h01 >= nextPage[blk]);
      OP_ERASE:
        // [RULE_13] no erase of bad block
        okToStart = !badBlock[blk] && writeProtectN;
      OP_READ:
        // [RULE_16] bad blocks stay closed
        okToStart = !badBlock[blk];
      OP_STATUS, OP_RESET, OP_MARKBAD:
        okToStart = 1'b1;
      default:
        okToStart = 1'b0;
    endcase
  end

  // Address and configuration registers written by software.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      addrReg <= ADDR_RESET;
      writeProtectN <= CONFIG_RESET;
    end
    else if (regWrite)
    begin
      if (regAddr == REG_ADDR && state == S_IDLE)
        addrReg <= regWdata[18:0];
      // [RULE_07] protect level driven from config
      if (regAddr == REG_CONFIG)
        writeProtectN <= regWdata[0];
    end
  end

  // Program byte holding register; a new write wins over consumption.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wrByte <= 8'h00;
      wrFull <= 1'b0;
    end
    else if (regWrite && regAddr == REG_DATA)
    begin
      wrByte <= regWdata[7:0];
      wrFull <= 1'b1;
    end
    else if (state == S_DATA && !issued && inSeg && wrFull && !abortReq)
      wrFull <= 1'b0;
  end

  // Read byte holding register; a captured byte wins over a software pop.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rdByte <= 8'h00;
      rdValid <= 1'b0;
    end
    // [RULE_17] read-back lets software verify
    else if (state == S_READ && issued && cyc.done)
    begin
      rdByte <= cyc.rByte;
      rdValid <= 1'b1;
    end
    else if (regRead && regAddr == REG_DATA)
      rdValid <= 1'b0;
  end

  // Abort request: only a reset may interrupt a pending program.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      abortReq <= 1'b0;
    else if (startWr && startOp == OP_RESET && state == S_DATA)
      abortReq <= 1'b1;
    else if (state != S_DATA)
      abortReq <= 1'b0;
  end

  // Per-block tables: bad marks and next programmable page.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < BLOCKS; i++)
      begin
        badBlock[i] <= 1'b0;
        nextPage[i] <= 7'h00;
      end
    end
    else if (state == S_IDLE && startWr && okToStart)
    begin
      // [RULE_12] software marks blocks found not all-ones
      // [RULE_14] table covers every block, any count bad
      if (startOp == OP_MARKBAD)
        badBlock[blk] <= 1'b1;
      if (startOp == OP_PROGRAM)
        nextPage[blk] <= {1'b0, page} + 7'h01;
    end
    else if (state == S_STRD && issued && cyc.done && op != OP_STATUS)
    begin
      // [RULE_15] failure retires the block
      // [RULE_16] failed erase recorded bad
      if (cyc.rByte[ST_FAIL])
        badBlock[blk] <= 1'b1;
      else if (op == OP_ERASE)
        nextPage[blk] <= 7'h00;
    end
  end

  // Operation sequencer driving the byte cycle engine.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= S_IDLE;
      issued <= 1'b0;
      op <= 3'h0;
      firstCmd <= 8'h00;
      secondCmd <= 8'h00;
      addrIdx <= 2'h0;
      col <= 12'h000;
      left <= 12'h000;
      settle <= 3'h0;
      devStatus <= 8'h00;
      refused <= 1'b0;
      failed <= 1'b0;
      chipEnableN <= 1'b1;
      cyc.req <= 1'b0;
      cyc.kind <= KIND_CMD;
      cyc.wByte <= 8'h00;
    end
    else
    begin
      cyc.req <= 1'b0;
      case (state)
        S_IDLE:
          if (startWr)
          begin
            refused <= !okToStart;
            if (okToStart && startOp != OP_MARKBAD)
            begin
              op <= startOp;
              failed <= 1'b0;
              chipEnableN <= 1'b0;
              col <= (startOp == OP_READ) ? segStart(seg) : 12'h000;
              left <= segLen(seg);
              addrIdx <= (startOp == OP_ERASE) ? 2'h2 : 2'h0;
              case (startOp)
                OP_READ:
                begin
                  firstCmd <= CMD_READ;
                  secondCmd <= CMD_READ_GO;
                end
                OP_PROGRAM:
                begin
                  firstCmd <= CMD_SERIAL_IN;
                  secondCmd <= CMD_PROG_GO;
                end
                OP_ERASE:
                begin
                  firstCmd <= CMD_ERASE;
                  secondCmd <= CMD_ERASE_GO;
                end
                default:
                  firstCmd <= CMD_RESET;
              endcase
              state <= (startOp == OP_STATUS) ? S_STCMD : S_CMD1;
            end
          end
        S_CMD1, S_CMD2, S_STCMD:
          if (!issued)
          begin
            cyc.req <= 1'b1;
            cyc.kind <= KIND_CMD;
            // [RULE_20] reset command byte
            cyc.wByte <= (state == S_CMD1) ? firstCmd
                       : (state == S_CMD2) ? secondCmd : CMD_STATUS;
            issued <= 1'b1;
          end
          else if (cyc.done)
          begin
            issued <= 1'b0;
            if (state == S_STCMD)
              state <= S_STRD;
            else if (state == S_CMD2 || op == OP_RESET)
            begin
              settle <= SETTLE_COUNT;
              state <= S_SETTLE;
            end
            else
              state <= S_ADDR;
          end
        S_ADDR:
          if (!issued)
          begin
            cyc.req <= 1'b1;
            cyc.kind <= KIND_ADDR;
            cyc.wByte <= addrByte(addrIdx, col, blk, page);
            issued <= 1'b1;
          end
          else if (cyc.done)
          begin
            issued <= 1'b0;
            addrIdx <= addrIdx + 2'h1;
            if (addrIdx == 2'h3)
              state <= (op == OP_PROGRAM) ? S_DATA : S_CMD2;
          end
        S_DATA:
          if (!issued)
          begin
            // [RULE_01] only confirm or reset follow serial input
            // [RULE_02] reset here cancels the pending program
            if (abortReq)
            begin
              op <= OP_RESET;
              firstCmd <= CMD_RESET;
              state <= S_CMD1;
            end
            else if (!inSeg || wrFull)
            begin
              // [RULE_09] one segment per pass
              // [RULE_11] all-ones outside the segment
              cyc.req <= 1'b1;
              cyc.kind <= KIND_WRITE;
              cyc.wByte <= inSeg ? wrByte : 8'hff;
              issued <= 1'b1;
            end
          end
          else if (cyc.done)
          begin
            issued <= 1'b0;
            col <= col + 12'h001;
            if (col == PAGE_LAST_COL)
              state <= S_CMD2;
          end
        S_SETTLE:
          // The busy pin is not valid until the settle time has passed.
          if (settle == 3'h0)
            state <= S_WAIT;
          else
            settle <= settle - 3'h1;
        S_WAIT:
          // [RULE_19] nothing is issued while busy
          if (readyBusyOutput)
            state <= (op == OP_READ) ? S_READ : (op == OP_RESET) ? S_END : S_STCMD;
        S_STRD:
          if (!issued)
          begin
            cyc.req <= 1'b1;
            cyc.kind <= KIND_READ;
            issued <= 1'b1;
          end
          else if (cyc.done)
          begin
            issued <= 1'b0;
            // [RULE_18] latch device status byte
            devStatus <= cyc.rByte;
            failed <= (op != OP_STATUS) && cyc.rByte[ST_FAIL];
            state <= S_END;
          end
        S_READ:
          // [RULE_05] no status command mid-read
          if (!issued && !rdValid)
          begin
            cyc.req <= 1'b1;
            cyc.kind <= KIND_READ;
            issued <= 1'b1;
          end
          else if (issued && cyc.done)
          begin
            issued <= 1'b0;
            left <= left - 12'h001;
            if (left == 12'h001)
              state <= S_END;
          end
        S_END:
        begin
          chipEnableN <= 1'b1;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // Register read data, valid in the cycle after the read strobe.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      regRdata <= 32'h00000000;
    else if (regRead)
    begin
      case (regAddr)
        REG_CTRL: regRdata <= {29'h00000000, op};
        REG_ADDR: regRdata <= {13'h0000, addrReg};
        REG_DATA: regRdata <= {24'h000000, rdByte};
        REG_STATUS: regRdata <= {16'h0000, devStatus, 2'h0, writeProtectN, failed, refused,
          rdValid, (state == S_DATA) && inSeg && !wrFull, state != S_IDLE};
        REG_CONFIG: regRdata <= {31'h00000000, writeProtectN};
        REG_BLOCKINFO: regRdata <= {24'h000000, badBlock[blk], nextPage[blk]};
        default: regRdata <= 32'h00000000;
      endcase
    end
    else
      regRdata <= 32'h00000000;
  end

  nand_cycle engine (
    .clock(clock),
    .nrst(nrst),
    .cyc(cyc.engine),
    .ioIn(ioIn),
    .ioOut(ioOut),
    .ioOe(ioOe),
    .cle(cle),
    .ale(ale),
    .writeStrobeN(writeStrobeN),
    .readStrobeN(readStrobeN)
  );
endmodule
`default_nettype wire

/* verification/nand_dev_model.sv */
// Behavioural flash device that answers the host controller's pins.
`timescale 1ns/100ps
`default_nettype none
module nand_dev_model
(
  input wire logic clock,
  input wire logic [7:0] ioOut,
  input wire logic cle,
  input wire logic ale,
  input wire logic chipEnableN,
  input wire logic writeStrobeN,
  input wire logic readStrobeN,
  input wire logic writeProtectN,
  output logic [7:0] ioIn,
  output logic readyBusyOutput
);
  // every block starts good and erased
  logic [7:0] mem [int];
  logic [7:0] pend [int];
  logic [7:0] cmd = 8'h00;
  logic [11:0] col = 12'h0;
  logic [15:0] row = 16'h0;
  logic [7:0] segs = 8'h0;
  logic statusMode = 1'b0;
  logic fail = 1'b0;
  logic failNext = 1'b0;
  int nAddr = 0;
  int busy = 0;
  int nProg = 0;
  int nErase = 0;
  int outside = 0;

  wire logic [7:0] status = {writeProtectN, 1'b0, busy == 0, 4'h0, fail};
  assign readyBusyOutput = (busy == 0);

  function automatic int segOf(input logic [11:0] c);
    return c < 12'h800 ? int'(c[10:9]) : 4 + int'(c[5:4]);
  endfunction

  // Bytes are taken at the rising write strobe, while the host still holds the pins.
  always @(posedge writeStrobeN)
  begin
    if (!chipEnableN && cle)
    begin
      if (ioOut != 8'h10)
        pend.delete();
      statusMode = (ioOut == 8'h70);
      if (writeProtectN && (ioOut == 8'h10 && cmd == 8'h80 || ioOut == 8'hd0))
      begin
        fail = failNext;
        failNext = 1'b0;
        busy = 20;
        nProg += (ioOut == 8'h10);
        nErase += (ioOut == 8'hd0);
        outside += ($countones(segs) > 1);
        foreach (pend[k])
          mem[k] = pend[k];
      end
      if (ioOut == 8'h30)
        busy = 20;
      if (ioOut == 8'hff)
        busy = 0;
      cmd = ioOut;
      nAddr = (ioOut == 8'h60) ? 2 : 0;
      segs = 8'h0;
    end
    else if (!chipEnableN && ale)
    begin
      case (nAddr)
        0: col[7:0] = ioOut;
        1: col[11:8] = ioOut[3:0];
        2: row[7:0] = ioOut;
        3: row[15:8] = ioOut;
        default: ;
      endcase
      nAddr++;
    end
    else if (!chipEnableN && cmd == 8'h80)
    begin
      if (ioOut != 8'hff)
        segs[segOf(col)] = 1'b1;
      pend[{row, 4'h0, col}] = ioOut;
      col++;
    end
  end

  always @(negedge readStrobeN)
    ioIn = statusMode ? status :
      (mem.exists({row, 4'h0, col}) ? mem[{row, 4'h0, col}] : 8'hff);

  // A released bus shows the inverse of the last byte, so stale data never match.
  always @(posedge readStrobeN)
  begin
    ioIn = ~ioIn;
    col = statusMode ? col : col + 12'h1;
  end

  // Busy counts down in host clocks.
  always @(posedge clock)
  begin
    if (!writeProtectN && cmd != 8'h30)
      busy <= 0;
    else if (busy > 0)
      busy <= busy - 1;
  end
endmodule
`default_nettype wire

/* verification/nand_host_monitor.sv */
// Checker for the flash host pins and its register read port.
`timescale 1ns/100ps
`default_nettype none
module nand_host_monitor
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic [7:0] ioOut,
  input wire logic ioOe,
  input wire logic cle,
  input wire logic writeStrobeN,
  input wire logic readStrobeN,
  input wire logic writeProtectN,
  input wire logic readyBusyOutput
);
  logic [7:0] lastCmd;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Last command byte, kept because order checks need the previous one.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      lastCmd <= 8'h00;
    else if (cle && !writeStrobeN)
      lastCmd <= ioOut;
  end

  AST_RDATA_IDLE:
    assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside answer cycle");
  AST_WRITE_LOW2:
    assert property ($fell(writeStrobeN) |=> !writeStrobeN ##1 writeStrobeN)
    else $error("write strobe width wrong");
  AST_READ_LOW2:
    assert property ($fell(readStrobeN) |=> !readStrobeN ##1 readStrobeN)
    else $error("read strobe width wrong");
  AST_ONE_STROBE:
    assert property (!(!writeStrobeN && !readStrobeN))
    else $error("both strobes low");
  AST_AFTER_SERIAL:
    assert property ($fell(writeStrobeN) && cle && lastCmd == 8'h80
      |-> ioOut inside {8'h10, 8'hff})
    else $error("bad command after serial input");
  AST_BUSY_CMD:
    assert property ($fell(writeStrobeN) && cle && !readyBusyOutput
      |-> ioOut inside {8'h70, 8'hff})
    else $error("command while busy");
  AST_PROTECT:
    assert property ($fell(writeStrobeN) && cle && !writeProtectN
      |-> !(ioOut inside {8'h80, 8'h60}))
    else $error("write started while protected");
  AST_STATUS_AFTER:
    assert property ($fell(writeStrobeN) && cle && ioOut inside {8'h10, 8'hd0}
      |-> ##[1:1000] ($fell(writeStrobeN) && cle && ioOut == 8'h70))
    else $error("no status read after write");
  AST_OE_DIR:
    assert property (!(writeStrobeN && readStrobeN) |-> ioOe == !writeStrobeN)
    else $error("data bus direction wrong");
endmodule

bind nand_host nand_host_monitor u_mon (.clock, .nrst, .regRead, .regRdata, .ioOut, .ioOe, .cle,
  .writeStrobeN, .readStrobeN, .writeProtectN, .readyBusyOutput);
`default_nettype wire

/* verification/nand_host_tb.sv */
// Self-checking bench: host controller against a behavioural flash device.
`timescale 1ns/100ps
`default_nettype none
module nand_host_tb
  import nand_host_pkg::*;
;
  logic clock = 1'b0;
  logic nrst;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  logic [7:0] ioIn;
  logic [7:0] ioOut;
  logic ioOe;
  logic cle;
  logic ale;
  logic chipEnableN;
  logic writeStrobeN;
  logic readStrobeN;
  logic writeProtectN;
  logic readyBusyOutput;
  logic rdPend = 1'b0;
  logic [31:0] expQ [$];
  logic [31:0] mskQ [$];
  logic [7:0] data [16];
  logic [31:0] seed = 32'h8736;
  int nErrors = 0;
  int totalChecks = 0;
  int cycles = 0;

  nand_host u_dut (.clock, .nrst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .ioIn,
    .ioOut, .ioOe, .cle, .ale, .chipEnableN, .writeStrobeN, .readStrobeN, .writeProtectN,
    .readyBusyOutput);
  nand_dev_model u_dev (.clock, .ioOut, .cle, .ale, .chipEnableN, .writeStrobeN, .readStrobeN,
    .writeProtectN, .ioIn, .readyBusyOutput);

  // Free-running clock, 20 ns period.
  always #10 clock = ~clock;

  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // A read that notes its expected value for the watcher.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock);
    mskQ.push_back(m);
    expQ.push_back(e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
  endtask

  // A read for flow control only; nothing is noted, so the watcher skips it.
  task automatic peek(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    v = regRdata;
  endtask

  task automatic waitSt(input int b, input logic want);
    logic [31:0] v;
    v = {32{~want}};
    for (int i = 0; i < 20000 && v[b] !== want; i++)
      peek(REG_STATUS, v);
  endtask

  // Read data stand one cycle after the strobe; the oldest note is compared then.
  always @(posedge clock)
    rdPend <= regRead;
  always @(negedge clock)
  begin
    if (rdPend && expQ.size() != 0)
      check(regRdata & mskQ.pop_front(), expQ.pop_front());
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      nErrors++;
      conclude();
    end
  end

  initial
  begin
    nrst = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    check(32'(writeProtectN), 32'h0);
    rd(REG_CONFIG, 32'h1, 32'h0);
    rd(REG_STATUS, 32'h1f, 32'h0);
    wr(8'h18, 32'h5a);
    rd(8'h18, 32'hffffffff, 32'h0);
    wr(REG_CTRL, 32'(OP_STATUS));
    waitSt(0, 1'b0);
    rd(REG_STATUS, 32'hff20, 32'h2000);
    wr(REG_ADDR, 32'h40401);
    wr(REG_CTRL, 32'(OP_PROGRAM));
    rd(REG_STATUS, 32'h9, 32'h8);
    $display("reset and protect test done");
    wr(REG_CONFIG, 32'h1);
    wr(REG_CTRL, 32'(OP_PROGRAM));
    for (int i = 0; i < 16; i++)
    begin
      waitSt(1, 1'b1);
      seed = xs(seed);
      data[i] = seed[7:0];
      wr(REG_DATA, {24'h0, data[i]});
    end
    waitSt(0, 1'b0);
    rd(REG_STATUS, 32'h10, 32'h0);
    rd(REG_BLOCKINFO, 32'hff, 32'h2);
    check(32'(u_dev.outside), 32'h0);
    wr(REG_CTRL, 32'(OP_READ));
    for (int i = 0; i < 16; i++)
    begin
      waitSt(2, 1'b1);
      rd(REG_DATA, 32'hff, {24'h0, data[i]});
    end
    waitSt(0, 1'b0);
    $display("spare segment test done");
    wr(REG_ADDR, 32'h40001);
    wr(REG_CTRL, 32'(OP_PROGRAM));
    rd(REG_STATUS, 32'h9, 32'h8);
    wr(REG_ADDR, 32'h801);
    wr(REG_CTRL, 32'(OP_PROGRAM));
    waitSt(1, 1'b1);
    wr(REG_DATA, 32'h11);
    wr(REG_CTRL, 32'(OP_RESET));
    waitSt(0, 1'b0);
    check(32'(u_dev.nProg), 32'h1);
    $display("order and abort test done");
    u_dev.failNext = 1'b1;
    wr(REG_ADDR, 32'h2);
    wr(REG_CTRL, 32'(OP_ERASE));
    waitSt(0, 1'b0);
    rd(REG_STATUS, 32'h10, 32'h10);
    rd(REG_BLOCKINFO, 32'h80, 32'h80);
    wr(REG_CTRL, 32'(OP_ERASE));
    rd(REG_STATUS, 32'h9, 32'h8);
    check(32'(u_dev.nErase), 32'h1);
    wr(REG_ADDR, 32'h3);
    wr(REG_CTRL, 32'(OP_MARKBAD));
    rd(REG_BLOCKINFO, 32'h80, 32'h80);
    $display("erase failure test done");
    conclude();
  end
endmodule
`default_nettype wire
